// File: pkg/disp_cmd_defs.vh
// Command codes, status layouts, reset values and timing for the command interpreter
`ifndef DISP_CMD_DEFS_VH
`define DISP_CMD_DEFS_VH
`define CMD_SOFT_RESET 8'h01
`define CMD_READ_POWER_MODE 8'h0a
`define CMD_READ_SCAN_ORDER 8'h0b
`define CMD_READ_IMAGE_MODE 8'h0d
`define CMD_SLEEP_ENTER 8'h10
`define CMD_SLEEP_EXIT 8'h11
`define CMD_PAGE_SELECT 8'hff
`define PWR_IDLE_BIT 6
`define PWR_AWAKE_BIT 4
`define PWR_NORMAL_BIT 3
`define PWR_DISP_BIT 2
`define SCAN_BGR_BIT 3
`define SCAN_HNORM_BIT 1
`define SCAN_VFLIP_BIT 0
`define IMG_INVERT_BIT 5
`define POWER_MODE_RESET 8'h08
`define SCAN_ORDER_RESET 8'h03
`define IMAGE_MODE_RESET 8'h00
`define PAGE_SELECT_RESET 8'hff
`define CLK_PERIOD_NS 10
`define SLEEP_ENTER_TIME_MS 10
`define SLEEP_EXIT_TIME_MS 120
`define SOFT_RESET_TIME_MS 10
`define NS_PER_MS 1000000
`endif

// File: hw/disp_power_cmd.v
// Power, reset and status command interpreter for the display module
`timescale 1ns/10ps
`include "disp_cmd_defs.vh"

module disp_power_cmd #(
	parameter SLEEP_ENTER_CYCLES = (`SLEEP_ENTER_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
	parameter SLEEP_EXIT_CYCLES = (`SLEEP_EXIT_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
	parameter SOFT_RESET_CYCLES = (`SOFT_RESET_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
	parameter CNT_W = 24
) (
	input wire sys_clk,
	input wire rst_b,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire [7:0] cmd_param,
	input wire [7:0] scan_order_setting,
	input wire scan_order_load,
	input wire idle_mode,
	input wire display_on,
	input wire invert_on,
	output reg rd_valid,
	output reg [7:0] rd_data,
	output wire busy,
	output reg asleep,
	output reg dcdc_en,
	output reg scan_en,
	output reg blank,
	output reg [7:0] page_select
);

	localparam ST_SLEEP = 5'b00001;
	localparam ST_WAKING = 5'b00010;
	localparam ST_AWAKE = 5'b00100;
	localparam ST_SLEEPING = 5'b01000;
	localparam ST_SRESET = 5'b10000;

	// Soft reset phases: blank, load defaults, settle
	localparam SR_BLANK = 3'b001;
	localparam SR_LOAD = 3'b010;
	localparam SR_SETTLE = 3'b100;
	localparam [7:0] SCAN_DEFAULT = `SCAN_ORDER_RESET;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg [3:0] scan_q;
	reg [7:0] page_q;
	reg idle_q;
	reg disp_q;
	reg inv_q;
	wire soft_reset_action;
	wire [7:0] power_mode_status;
	wire [7:0] scan_order_status;
	wire [7:0] image_mode_status;
	wire cmd_sleep_enter;
	wire cmd_sleep_exit;
	wire cmd_page_select;
	wire cmd_is_read;
	reg [2:0] sr_phase_q;
	reg [2:0] sr_phase_d;
	reg awake_q;
	wire load_defaults;
	genvar bit_i;

	assign soft_reset_action = cmd_valid && (cmd_code == `CMD_SOFT_RESET);
	assign busy = (state_q != ST_SLEEP) && (state_q != ST_AWAKE);

	// Command decode
	assign cmd_sleep_enter = cmd_valid && (cmd_code == `CMD_SLEEP_ENTER);
	assign cmd_sleep_exit = cmd_valid && (cmd_code == `CMD_SLEEP_EXIT);
	assign cmd_page_select = cmd_valid && (cmd_code == `CMD_PAGE_SELECT);
	assign cmd_is_read = cmd_valid && ((cmd_code == `CMD_READ_POWER_MODE) ||
		(cmd_code == `CMD_READ_SCAN_ORDER) || (cmd_code == `CMD_READ_IMAGE_MODE) ||
		(cmd_code == `CMD_PAGE_SELECT));
	assign load_defaults = soft_reset_action || (sr_phase_q == SR_LOAD);

	// Sleep bit follows completed state, but clears at once on soft reset
	assign power_mode_status = {1'b0, idle_q, 1'b0, awake_q,
		1'b1, disp_q, 2'b00};

	// Scan status reports only the colour and flip bits
	generate
		for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1) begin : g_scan_bits
			if ((bit_i == `SCAN_BGR_BIT) || (bit_i == `SCAN_HNORM_BIT) ||
				(bit_i == `SCAN_VFLIP_BIT)) begin : g_used
				assign scan_order_status[bit_i] = scan_q[bit_i];
			end else begin : g_unused
				assign scan_order_status[bit_i] = 1'b0;
			end
		end
	endgenerate
	assign image_mode_status = {2'b00, inv_q, 5'b00000};

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (cnt_q != {CNT_W{1'b0}}) begin
			cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
		end
		case (state_q)
			ST_SLEEP: begin
				if (cmd_sleep_exit) begin
					state_d = ST_WAKING;
					cnt_d = SLEEP_EXIT_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
				end else if (cmd_sleep_enter) begin
					state_d = ST_SLEEP;
				end
			end
			ST_WAKING: begin
				if (cnt_q == {CNT_W{1'b0}}) begin
					state_d = ST_AWAKE;
				end
			end
			ST_AWAKE: begin
				if (cmd_sleep_enter) begin
					state_d = ST_SLEEPING;
					cnt_d = SLEEP_ENTER_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
				end else if (cmd_sleep_exit) begin
					state_d = ST_AWAKE;
				end
			end
			ST_SLEEPING: begin
				if (cnt_q == {CNT_W{1'b0}}) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SRESET: begin
				if (cnt_q == {CNT_W{1'b0}}) begin
					state_d = ST_SLEEP;
				end
			end
			default: begin
				state_d = ST_SLEEP;
			end
		endcase
		// Sleep enter while asleep leaves state untouched
		if (soft_reset_action) begin
			state_d = ST_SRESET;
			cnt_d = SOFT_RESET_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_SLEEP;
			cnt_q <= {CNT_W{1'b0}};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Soft reset runs blank, then defaults, then settles into sleep
	always @* begin
		sr_phase_d = sr_phase_q;
		case (sr_phase_q)
			SR_BLANK: begin
				if (state_q == ST_SRESET) begin
					sr_phase_d = SR_LOAD;
				end
			end
			SR_LOAD: begin
				sr_phase_d = SR_SETTLE;
			end
			SR_SETTLE: begin
				if (state_q != ST_SRESET) begin
					sr_phase_d = SR_BLANK;
				end
			end
			default: begin
				sr_phase_d = SR_BLANK;
			end
		endcase
		if (soft_reset_action) begin
			sr_phase_d = SR_BLANK;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sr_phase_q <= SR_BLANK;
			awake_q <= 1'b0;
		end else begin
			sr_phase_q <= sr_phase_d;
			// Sleep bit moves when a transition finishes, and clears as soon as defaults load
			if (load_defaults) begin
				awake_q <= 1'b0;
			end else if ((state_q == ST_WAKING) && (state_d == ST_AWAKE)) begin
				awake_q <= 1'b1;
			end else if ((state_q == ST_SLEEPING) && (state_d == ST_SLEEP)) begin
				awake_q <= 1'b0;
			end
		end
	end

	// Settings: hardware reset and soft reset both load defaults
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_q <= SCAN_DEFAULT[3:0];
			page_q <= `PAGE_SELECT_RESET;
			idle_q <= 1'b0;
			disp_q <= 1'b0;
			inv_q <= 1'b0;
		end else if (load_defaults) begin
			scan_q <= SCAN_DEFAULT[3:0];
			page_q <= `PAGE_SELECT_RESET;
			idle_q <= 1'b0;
			disp_q <= 1'b0;
			inv_q <= 1'b0;
		end else begin
			if (scan_order_load) begin
				scan_q <= scan_order_setting[3:0];
			end
			if (cmd_page_select) begin
				page_q <= cmd_param;
			end
			idle_q <= idle_mode;
			disp_q <= display_on && (state_q != ST_SRESET);
			inv_q <= invert_on;
		end
	end

	// Status readback, answered one cycle after the read command
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			if (cmd_is_read) begin
				case (cmd_code)
					`CMD_READ_POWER_MODE: begin
						rd_valid <= 1'b1;
						rd_data <= power_mode_status;
					end
					`CMD_READ_SCAN_ORDER: begin
						rd_valid <= 1'b1;
						rd_data <= scan_order_status;
					end
					`CMD_READ_IMAGE_MODE: begin
						rd_valid <= 1'b1;
						rd_data <= image_mode_status;
					end
					`CMD_PAGE_SELECT: begin
						rd_valid <= 1'b1;
						rd_data <= page_q;
					end
					default: begin
						rd_valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// Power outputs: converter and scanning run only while waking or awake
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			asleep <= 1'b1;
			dcdc_en <= 1'b0;
			scan_en <= 1'b0;
			blank <= 1'b1;
			page_select <= `PAGE_SELECT_RESET;
		end else begin
			asleep <= (state_d == ST_SLEEP) || (state_d == ST_SRESET);
			dcdc_en <= (state_d == ST_WAKING) || (state_d == ST_AWAKE);
			scan_en <= (state_d == ST_WAKING) || (state_d == ST_AWAKE);
			blank <= (state_d != ST_AWAKE) || soft_reset_action;
			page_select <= soft_reset_action ? `PAGE_SELECT_RESET : page_q;
		end
	end

endmodule // disp_power_cmd

// File: testbench/disp_power_cmd_properties.sv
// Concurrent checks on the command interpreter ports
`timescale 1ns/10ps
module disp_power_cmd_properties #(parameter int SE = 20, parameter int EX = 40) (
	input wire sys_clk, rst_b, cmd_valid, input wire [7:0] cmd_code, cmd_param,
	input wire [7:0] scan_order_setting, input wire scan_order_load, idle_mode, display_on,
	input wire invert_on, rd_valid, input wire [7:0] rd_data, input wire busy, asleep,
	input wire dcdc_en, scan_en, blank, input wire [7:0] page_select);
	localparam int SE1 = SE + 1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_read_answer: assert property (cmd_valid && cmd_code inside {8'h0a, 8'h0b, 8'h0d,
		8'hff} |=> rd_valid) else $error("no read answer");
	chk_power_fixed: assert property (rd_valid && $past(cmd_code) == 8'h0a |->
		(rd_data & 8'hab) == 8'h08) else $error("fixed power bits wrong");
	chk_sleep_off: assert property (asleep |-> !dcdc_en && !scan_en && blank)
		else $error("power on while asleep");
	chk_exit_start: assert property (cmd_valid && cmd_code == 8'h11 && asleep && !busy |=>
		dcdc_en && scan_en && !asleep) else $error("wake not started");
	chk_exit_done: assert property ($fell(asleep) |-> ##[1:EX] !busy)
		else $error("wake too long");
	chk_enter_done: assert property (cmd_valid && cmd_code == 8'h10 && !asleep && !busy |->
		##[1:SE1] asleep) else $error("sleep entry too long");
	chk_soft_blank: assert property (cmd_valid && cmd_code == 8'h01 |=> asleep && blank)
		else $error("soft reset not blanked");
	chk_sleep_stay: assert property (asleep && !(cmd_valid && cmd_code == 8'h11) |=> asleep)
		else $error("left sleep wrongly");
	cover property (cmd_valid && cmd_code == 8'h11 && asleep);
	cover property (cmd_valid && cmd_code == 8'h10 && !asleep && !busy);
	cover property (cmd_valid && cmd_code == 8'h01);
endmodule // disp_power_cmd_properties

// File: testbench/host_model.sv
// Host that issues one command at a time; it waits out the soft reset and sleep enter times, but only EX / 12 cycles after sleep exit
`timescale 1ns/10ps
module host_model #(parameter int SE = 20, parameter int EX = 40, parameter int SR = 20) (
	input wire sys_clk, output reg cmd_valid, output reg [7:0] cmd_code, output reg [7:0] cmd_param);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_param = 8'h00;
	end
	task send(input [7:0] c, input [7:0] p);
		@(posedge sys_clk);
		#1 cmd_valid = 1'b1;
		cmd_code = c;
		cmd_param = p;
		@(posedge sys_clk);
		#1 cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_param = ~p;
		repeat (c == 8'h01 ? SR : c == 8'h10 ? 8 * SE : c == 8'h11 ? EX / 12 : 0)
			@(posedge sys_clk);
	endtask
endmodule // host_model

// File: testbench/display_power_status_commands_bench.sv
// Self-checking bench for the power and status command interpreter
`timescale 1ns/10ps
module display_power_status_commands_bench;
	localparam int SE = 20;
	localparam int EX = 40;
	reg sys_clk = 1'b0, rst_b = 1'b0, idle_mode = 1'b0, display_on = 1'b0, invert_on = 1'b0;
	reg scan_order_load = 1'b0;
	reg [7:0] scan_order_setting = 8'h00;
	wire cmd_valid, rd_valid, busy, asleep, dcdc_en, scan_en, blank;
	wire [7:0] cmd_code, cmd_param, rd_data, page_select;
	int err_total = 0, num_checks = 0, cyc = 0, aw = 0;
	initial forever #5 sys_clk = ~sys_clk;
	host_model #(.SE(SE), .EX(EX), .SR(SE)) host_model_i (.sys_clk(sys_clk),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param));
	disp_power_cmd #(.SLEEP_ENTER_CYCLES(SE), .SLEEP_EXIT_CYCLES(EX),
		.SOFT_RESET_CYCLES(SE)) disp_power_cmd_i (.*);
	task cmp(input string n, input [7:0] e, input [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task wrap_up;
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function [7:0] pwr;
		pwr = {1'b0, idle_mode, 1'b0, aw[0], 1'b1, display_on, 2'b00};
	endfunction
	task rd(input [7:0] c, input [7:0] p, input [7:0] e);
		host_model_i.send(c, p);
		cmp("rd_valid", 8'h01, {7'h00, rd_valid});
		cmp("rd_data", e, rd_data);
	endtask
	task flag(input string n, input e, input g);
		cmp(n, {7'h00, e}, {7'h00, g});
	endtask
	always @(posedge sys_clk) if (++cyc > 4000) begin
		err_total++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'he12a0ff3));
		repeat (6) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		rd(8'h0a, 8'h00, 8'h08);
		rd(8'h0b, 8'h00, 8'h03);
		rd(8'h0d, 8'h00, 8'h00);
		rd(8'hff, 8'h5a, 8'hff);
		rd(8'hff, 8'h00, 8'h5a);
		cmp("page_select", 8'h5a, page_select);
		host_model_i.send(8'h11, 8'h00);
		flag("dcdc_en", 1'b1, dcdc_en);
		rd(8'h0a, 8'h00, 8'h08);
		for (int i = 0; i < EX && busy !== 1'b0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		flag("busy", 1'b0, busy);
		flag("blank", 1'b0, blank);
		aw = 1;
		rd(8'h0a, 8'h00, 8'h18);
		host_model_i.send(8'h11, 8'h00);
		flag("busy", 1'b0, busy);
		for (int i = 0; i < 12; i++) begin
			{idle_mode, display_on, invert_on} = 3'($urandom);
			scan_order_setting = 8'($urandom);
			scan_order_load = 1'b1;
			@(posedge sys_clk);
			#1 scan_order_load = 1'b0;
			rd(8'h0a, 8'h00, pwr());
			rd(8'h0b, 8'h00, scan_order_setting & 8'h0b);
			rd(8'h0d, 8'h00, {2'b00, invert_on, 5'h00});
		end
		{idle_mode, display_on, invert_on} = 3'b000;
		host_model_i.send(8'h10, 8'h00);
		flag("asleep", 1'b1, asleep);
		flag("scan_en", 1'b0, scan_en);
		aw = 0;
		rd(8'h0a, 8'h00, pwr());
		host_model_i.send(8'h10, 8'h00);
		flag("busy", 1'b0, busy);
		host_model_i.send(8'h01, 8'h00);
		rd(8'h0a, 8'h00, 8'h08);
		rd(8'h0b, 8'h00, 8'h03);
		rd(8'hff, 8'h00, 8'hff);
		cmp("page_select", 8'hff, page_select);
		wrap_up;
	end
endmodule // display_power_status_commands_bench
bind disp_power_cmd disp_power_cmd_properties #(.SE(SLEEP_ENTER_CYCLES),
	.EX(SLEEP_EXIT_CYCLES)) chk_i (.*);
